// >>> rtl/spg_pkg.sv
// package: constants and carriers for the serial packetizer gateway
package spg_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MS_CYCLES = CLK_MHZ * 1000;
  localparam logic [7:0] GAP_MAX_MS = 8'hff;
  localparam logic [10:0] LEN_MAX = 11'h5b4;
  localparam logic [15:0] IDLE_RST_MS = 16'h000a;
  localparam logic [23:0] BAUD_RST = 24'h2580;
  localparam logic [5:0] REG_MAX = 6'h28;
  localparam int unsigned BITS_PER_CHAR = 10;
  localparam int unsigned MAX_CLIENTS = 16;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GAP = 8'h04;
  localparam logic [7:0] A_LEN = 8'h08;
  localparam logic [7:0] A_IDLE = 8'h0c;
  localparam logic [7:0] A_HB = 8'h10;
  localparam logic [7:0] A_BAUD = 8'h14;
  localparam logic [7:0] A_RTO = 8'h18;
  localparam logic [7:0] A_REGLEN = 8'h1c;
  localparam logic [7:0] A_REGDAT = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_HBDAT = 8'h28;
  localparam int unsigned C_GAP_EN = 0;
  localparam int unsigned C_GAP_MAN = 1;
  localparam int unsigned C_REG_PFX = 2;
  localparam int unsigned C_REG_ONCE = 3;
  localparam int unsigned C_HB_SER = 4;
  localparam int unsigned C_HB_NET = 5;
  localparam int unsigned C_M0 = 6;
  localparam int unsigned C_POLL = 8;
  localparam logic [1:0] MODE_TCPS = 2'h0;
  localparam logic [1:0] MODE_TCPC = 2'h1;
  localparam logic [1:0] MODE_UDP = 2'h2;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spg_byte_type;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } spg_net_type;
endpackage

// >>> rtl/spg_ms_tick.sv
// module: millisecond tick generator
`timescale 1ns/1ps
`default_nettype none
module spg_ms_tick #(
  parameter int unsigned CYCLES = spg_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  output logic tick_o
);
  logic [17:0] cnt;
  logic [17:0] next_cnt;
  logic next_tick;
  always_comb begin
    next_tick = (cnt == 18'(CYCLES - 1));
    next_cnt = next_tick ? 18'h0 : cnt + 18'h1;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 18'h0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule // spg_ms_tick
`default_nettype wire

// >>> rtl/spg_packetizer.sv
// module: serial to network packetizer with rs485 transmit gate
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spg_packetizer #(
  parameter int unsigned MS_CYC = spg_pkg::MS_CYCLES,
  parameter int unsigned BUF_DEPTH = 2048,
  parameter int unsigned CLIENTS = spg_pkg::MAX_CLIENTS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire spg_pkg::spg_byte_type ser_rx_i,
  input wire logic bus_rx_busy_i,
  input wire spg_pkg::spg_byte_type net_rx_i,
  input wire logic [3:0] net_rx_client_i,
  input wire logic net_conn_i,
  output spg_pkg::spg_net_type net_tx_o,
  output spg_pkg::spg_byte_type ser_tx_o,
  output logic [3:0] ser_tx_client_o,
  output logic poll_to_o,
  output logic [3:0] poll_to_client_o
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] ctrl, next_ctrl;
  logic [7:0] gap_ms, next_gap_ms;
  logic [10:0] len_cfg, next_len_cfg;
  logic [15:0] idle_ms, next_idle_ms;
  logic [15:0] hb_ms, next_hb_ms;
  logic [23:0] baud, next_baud;
  logic [15:0] rto_ms, next_rto_ms;
  logic [5:0] reg_len, next_reg_len;
  logic [7:0] hb_byte, next_hb_byte;
  logic [7:0] reg_mem [0:39];
  logic [31:0] next_rdata;
  logic ms;
  spg_ms_tick #(.CYCLES(MS_CYC)) u_tick (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_o(ms));
  logic client_mode;
  assign client_mode = (ctrl[spg_pkg::C_M0 +: 2] == spg_pkg::MODE_TCPC) ||
                       (ctrl[spg_pkg::C_M0 +: 2] == spg_pkg::MODE_UDP);
  // derived gap: one char ms rounded down plus two, capped at 255, so it exceeds a character time down to 40 baud
  function automatic logic [7:0] auto_gap(input logic [23:0] b);
    logic [31:0] q;
    q = (32'(spg_pkg::BITS_PER_CHAR) * 32'd1000) / ((b == 24'h0) ? 32'h1 : 32'(b)) + 32'h2;
    auto_gap = (q > 32'(spg_pkg::GAP_MAX_MS)) ? spg_pkg::GAP_MAX_MS : q[7:0];
  endfunction
  logic [7:0] gap_eff;
  assign gap_eff = ctrl[spg_pkg::C_GAP_MAN] ? gap_ms : auto_gap(baud);
  always_comb begin
    next_ctrl = ctrl;
    next_gap_ms = gap_ms;
    next_len_cfg = len_cfg;
    next_idle_ms = idle_ms;
    next_hb_ms = hb_ms;
    next_baud = baud;
    next_rto_ms = rto_ms;
    next_reg_len = reg_len;
    next_hb_byte = hb_byte;
    if (wr_i) begin
      unique case (addr_i)
        spg_pkg::A_CTRL: next_ctrl = wdata_i[15:0];
        spg_pkg::A_GAP: next_gap_ms = wdata_i[7:0];
        spg_pkg::A_LEN: next_len_cfg = (wdata_i[10:0] > spg_pkg::LEN_MAX) ? spg_pkg::LEN_MAX : wdata_i[10:0];
        spg_pkg::A_IDLE: next_idle_ms = wdata_i[15:0];
        spg_pkg::A_HB: next_hb_ms = wdata_i[15:0];
        spg_pkg::A_BAUD: next_baud = wdata_i[23:0];
        spg_pkg::A_RTO: next_rto_ms = wdata_i[15:0];
        spg_pkg::A_REGLEN: next_reg_len = (wdata_i[5:0] > spg_pkg::REG_MAX) ? spg_pkg::REG_MAX : wdata_i[5:0];
        spg_pkg::A_HBDAT: next_hb_byte = wdata_i[7:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (wr_i && addr_i[7:6] == 2'h1 && addr_i[5:0] < spg_pkg::REG_MAX)
      reg_mem[addr_i[5:0]] <= wdata_i[7:0];
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= 16'h0;
      gap_ms <= 8'h0;
      len_cfg <= 11'h0;
      idle_ms <= spg_pkg::IDLE_RST_MS;
      hb_ms <= 16'h0;
      baud <= spg_pkg::BAUD_RST;
      rto_ms <= 16'h0;
      reg_len <= 6'h0;
      hb_byte <= 8'h0;
    end else begin
      ctrl <= next_ctrl;
      gap_ms <= next_gap_ms;
      len_cfg <= next_len_cfg;
      idle_ms <= next_idle_ms;
      hb_ms <= next_hb_ms;
      baud <= next_baud;
      rto_ms <= next_rto_ms;
      reg_len <= next_reg_len;
      hb_byte <= next_hb_byte;
    end
  end
  // ------------------------------------------------------------
  // serial buffer and delimiters
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_FILL, S_PFX, S_DATA, S_ONCE} spg_out_type;
  spg_out_type ost, next_ost;
  logic [7:0] sbuf [0:BUF_DEPTH-1];
  logic [10:0] cnt, next_cnt;
  logic [10:0] rdp, next_rdp;
  logic [5:0] rp, next_rp;
  logic [8:0] gap_cnt, next_gap_cnt;
  logic flush, conn_d, next_conn_d, once_pend, next_once_pend;
  spg_pkg::spg_net_type next_net_tx;
  logic len_hit, gap_hit, room;
  // one slot stays free so the 11-bit count never wraps; the tick is free running,
  // so the gap needs one tick more than its value to be sure the full time passed
  always_comb begin
    room = 32'(cnt) < BUF_DEPTH - 1;
    len_hit = (len_cfg != 11'h0) && (cnt == len_cfg);
    gap_hit = ctrl[spg_pkg::C_GAP_EN] && (cnt != 11'h0) && (gap_eff == 8'h0 || gap_cnt > {1'b0, gap_eff});
    flush = (ost == S_FILL) && (len_hit || gap_hit);
  end
  always_comb begin
    next_ost = ost;
    next_cnt = cnt;
    next_rdp = rdp;
    next_rp = rp;
    next_gap_cnt = gap_cnt;
    next_conn_d = net_conn_i;
    next_once_pend = once_pend;
    next_net_tx = '0;
    if (net_conn_i && !conn_d && ctrl[spg_pkg::C_REG_ONCE] && client_mode && reg_len != 6'h0)
      next_once_pend = 1'b1;
    unique case (ost)
      S_FILL: begin
        if (ser_rx_i.valid && !flush && room) begin
          next_cnt = cnt + 11'h1;
          next_gap_cnt = 9'h0;
        end else if (ms && cnt != 11'h0 && gap_cnt != 9'h1ff) begin
          next_gap_cnt = gap_cnt + 9'h1;
        end
        if (flush) begin
          next_rdp = 11'h0;
          next_rp = 6'h0;
          next_gap_cnt = 9'h0;
          next_ost = (ctrl[spg_pkg::C_REG_PFX] && client_mode && reg_len != 6'h0) ? S_PFX : S_DATA;
        end else if (once_pend && cnt == 11'h0) begin
          next_rp = 6'h0;
          next_ost = S_ONCE;
        end
      end
      S_PFX: begin
        next_net_tx = '{valid: 1'b1, last: 1'b0, data: reg_mem[rp]};
        next_rp = rp + 6'h1;
        if (rp + 6'h1 == reg_len) next_ost = S_DATA;
      end
      S_DATA: begin
        next_net_tx = '{valid: 1'b1, last: (rdp + 11'h1 == cnt), data: sbuf[rdp]};
        next_rdp = rdp + 11'h1;
        if (rdp + 11'h1 == cnt) begin
          next_cnt = 11'h0;
          next_ost = S_FILL;
        end
      end
      S_ONCE: begin
        next_net_tx = '{valid: 1'b1, last: (rp + 6'h1 >= reg_len), data: reg_mem[rp]};
        next_rp = rp + 6'h1;
        next_once_pend = 1'b0;
        if (rp + 6'h1 >= reg_len) next_ost = S_FILL;
      end
    endcase
  end
  // serial bytes arriving while draining are dropped; the buffer is single banked to save area
  always_ff @(posedge clk_i) begin
    if (ost == S_FILL && ser_rx_i.valid && !flush && room)
      sbuf[cnt] <= ser_rx_i.data;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ost <= S_FILL;
      cnt <= 11'h0;
      rdp <= 11'h0;
      rp <= 6'h0;
      gap_cnt <= 9'h0;
      conn_d <= 1'b0;
      once_pend <= 1'b0;
      net_tx_o <= '0;
    end else begin
      ost <= next_ost;
      cnt <= next_cnt;
      rdp <= next_rdp;
      rp <= next_rp;
      gap_cnt <= next_gap_cnt;
      conn_d <= next_conn_d;
      once_pend <= next_once_pend;
      net_tx_o <= next_net_tx;
    end
  end
  // ------------------------------------------------------------
  // heartbeat, rs485 gate and polling timeout
  // ------------------------------------------------------------
  logic [15:0] hb_cnt, next_hb_cnt;
  logic [16:0] idle_cnt, next_idle_cnt;
  logic [15:0] rto_cnt, next_rto_cnt;
  logic waiting, next_waiting, bus_ok;
  logic [3:0] cur_cli, next_cur_cli;
  logic hb_fire, next_poll_to;
  logic [3:0] next_poll_cli;
  spg_pkg::spg_byte_type next_ser_tx;
  logic [3:0] next_tx_cli;
  logic traffic;
  always_comb begin
    traffic = ser_rx_i.valid || net_rx_i.valid;
    hb_fire = (hb_ms != 16'h0) && (hb_cnt >= hb_ms) && !traffic;
    next_hb_cnt = (traffic || hb_fire) ? 16'h0 : (ms && hb_cnt != 16'hffff) ? hb_cnt + 16'h1 : hb_cnt;
    next_idle_cnt = bus_rx_busy_i ? 17'h0 : (ms && idle_cnt != 17'h1ffff) ? idle_cnt + 17'h1 : idle_cnt;
    bus_ok = !bus_rx_busy_i && (idle_ms == 16'h0 || idle_cnt > {1'b0, idle_ms});
    next_ser_tx = '0;
    next_tx_cli = ser_tx_client_o;
    next_waiting = waiting;
    next_cur_cli = cur_cli;
    next_rto_cnt = (ms && waiting && rto_cnt != 16'hffff) ? rto_cnt + 16'h1 : rto_cnt;
    next_poll_to = 1'b0;
    next_poll_cli = poll_to_client_o;
    if (waiting && ser_rx_i.valid) next_waiting = 1'b0;
    if (waiting && rto_cnt >= rto_ms && !ser_rx_i.valid) begin
      next_waiting = 1'b0;
      next_poll_to = 1'b1;
      next_poll_cli = cur_cli;
    end
    if (bus_ok) begin
      if (net_rx_i.valid && 32'(net_rx_client_i) < CLIENTS) begin
        next_ser_tx = net_rx_i;
        next_tx_cli = net_rx_client_i;
        if (ctrl[spg_pkg::C_POLL]) begin
          next_waiting = 1'b1;
          next_rto_cnt = 16'h0;
          next_cur_cli = net_rx_client_i;
        end
      end else if (hb_fire && ctrl[spg_pkg::C_HB_SER]) begin
        next_ser_tx = '{valid: 1'b1, data: hb_byte};
      end
    end
  end
  logic net_hb;
  assign net_hb = hb_fire && ctrl[spg_pkg::C_HB_NET] && client_mode;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hb_cnt <= 16'h0;
      idle_cnt <= 17'h0;
      rto_cnt <= 16'h0;
      waiting <= 1'b0;
      cur_cli <= 4'h0;
      ser_tx_o <= '0;
      ser_tx_client_o <= 4'h0;
      poll_to_o <= 1'b0;
      poll_to_client_o <= 4'h0;
    end else begin
      hb_cnt <= next_hb_cnt;
      idle_cnt <= next_idle_cnt;
      rto_cnt <= next_rto_cnt;
      waiting <= next_waiting;
      cur_cli <= next_cur_cli;
      ser_tx_o <= next_ser_tx;
      ser_tx_client_o <= next_tx_cli;
      poll_to_o <= next_poll_to;
      poll_to_client_o <= next_poll_cli;
    end
  end
  // ------------------------------------------------------------
  // read port; net heartbeat is flagged in status for software to send
  // ------------------------------------------------------------
  logic hb_net_flag, next_hb_net_flag;
  always_comb begin
    next_hb_net_flag = net_hb ? 1'b1 : (rd_i && addr_i == spg_pkg::A_STAT) ? 1'b0 : hb_net_flag;
    next_rdata = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        spg_pkg::A_CTRL: next_rdata = {16'h0, ctrl};
        spg_pkg::A_GAP: next_rdata = {24'h0, gap_ms};
        spg_pkg::A_LEN: next_rdata = {21'h0, len_cfg};
        spg_pkg::A_IDLE: next_rdata = {16'h0, idle_ms};
        spg_pkg::A_HB: next_rdata = {16'h0, hb_ms};
        spg_pkg::A_BAUD: next_rdata = {8'h0, baud};
        spg_pkg::A_RTO: next_rdata = {16'h0, rto_ms};
        spg_pkg::A_REGLEN: next_rdata = {26'h0, reg_len};
        spg_pkg::A_HBDAT: next_rdata = {24'h0, hb_byte};
        spg_pkg::A_STAT: next_rdata = {hb_net_flag, waiting, bus_ok, 1'b0, 2'(ost), gap_eff, 7'h0, cnt};
        default: next_rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0;
      hb_net_flag <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      hb_net_flag <= next_hb_net_flag;
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  len_flush_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ost == S_FILL && len_cfg != 11'h0 && cnt == len_cfg) |=> (ost != S_FILL))
    else $error("length match did not flush");
  len_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ost == S_FILL && len_cfg == 11'h0 && !ctrl[spg_pkg::C_GAP_EN] && !once_pend) |=> (ost == S_FILL))
    else $error("flush with both delimiters off");
  gap_flush_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ost == S_FILL && gap_hit) |=> (ost inside {S_PFX, S_DATA} && gap_cnt == 9'h0))
    else $error("gap expiry did not flush");
  either_flush_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ost == S_FILL && $past(ost) == S_FILL && $past(ost, 2) == S_FILL && next_ost inside {S_PFX, S_DATA})
    |-> (len_hit || gap_hit)) else $error("flush without delimiter");
  bus_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(bus_rx_busy_i) |-> !ser_tx_o.valid) else $error("transmit while bus receiving");
  idle_wait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ser_tx_o.valid |-> ($past(idle_ms) == 16'h0 || $past(idle_cnt) > {1'b0, $past(idle_ms)}))
    else $error("transmit before idle time");
  prefix_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ost == S_FILL ##1 ost == S_PFX) |=> (net_tx_o.valid && !net_tx_o.last && net_tx_o.data == reg_mem[0]))
    else $error("prefix not sent first");
  net_hb_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    net_hb |=> hb_net_flag && (ctrl[spg_pkg::C_M0 +: 2] != spg_pkg::MODE_TCPS)) else $error("net heartbeat bad mode");
  poll_to_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (waiting && rto_cnt >= rto_ms && !ser_rx_i.valid) |=> (poll_to_o && !waiting && poll_to_client_o == $past(cur_cli)))
    else $error("poll timeout missed");
endmodule // spg_packetizer
`default_nettype wire

// >>> dv/spg_far_model.sv
// far-side model: serial instrument on the rs485 bus and the network socket layer
`timescale 1ns/1ps
`default_nettype none
module spg_far_model (
  input wire logic clk_i,
  output spg_pkg::spg_byte_type ser_rx_o,
  output logic bus_busy_o,
  output spg_pkg::spg_byte_type net_rx_o,
  output logic [3:0] net_client_o,
  output logic net_conn_o,
  input wire spg_pkg::spg_net_type net_tx_i,
  input wire spg_pkg::spg_byte_type ser_tx_i,
  input wire logic [3:0] ser_tx_client_i
);
  logic [8:0] net_q[$];
  logic [11:0] ser_q[$];
  // requests are staged and launched on the next edge, so each output has one driver
  spg_pkg::spg_byte_type ser_rx_q = '0;
  spg_pkg::spg_byte_type net_rx_q = '0;
  logic [3:0] net_client_q = 4'h0;
  logic bus_busy_q = 1'b0;
  logic net_conn_q = 1'b0;
  always @(posedge clk_i) begin
    ser_rx_o <= ser_rx_q;
    net_rx_o <= net_rx_q;
    net_client_o <= net_client_q;
    bus_busy_o <= bus_busy_q;
    net_conn_o <= net_conn_q;
  end
  // --------------------------------------------------
  // drivers
  // --------------------------------------------------
  // released data lines show the inverted byte so a stale value never passes as fresh
  task automatic ser_byte(input logic [7:0] b);
    @(posedge clk_i);
    ser_rx_q <= '{valid: 1'b1, data: b};
    @(posedge clk_i);
    ser_rx_q <= '{valid: 1'b0, data: ~b};
  endtask
  task automatic net_byte(input logic [7:0] b, input logic [3:0] c);
    @(posedge clk_i);
    net_rx_q <= '{valid: 1'b1, data: b};
    net_client_q <= c;
    @(posedge clk_i);
    net_rx_q <= '{valid: 1'b0, data: ~b};
    net_client_q <= ~c;
  endtask
  task automatic set_busy(input logic v);
    @(posedge clk_i);
    bus_busy_q <= v;
  endtask
  task automatic set_conn(input logic v);
    @(posedge clk_i);
    net_conn_q <= v;
  endtask
  // --------------------------------------------------
  // collectors
  // --------------------------------------------------
  always @(posedge clk_i) begin
    if (net_tx_i.valid === 1'b1) net_q.push_back({net_tx_i.last, net_tx_i.data});
    if (ser_tx_i.valid === 1'b1) ser_q.push_back({ser_tx_client_i, ser_tx_i.data});
  end
endmodule // spg_far_model
`default_nettype wire

// >>> dv/tb.sv
// testbench: register tasks and scenarios for the serial packetizer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, sys_rst_i, wr_i, rd_i, busy, conn, poll_to;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rv;
  spg_pkg::spg_byte_type ser_rx, net_rx, ser_tx;
  spg_pkg::spg_net_type net_tx;
  logic [3:0] net_client, ser_client, poll_client;
  logic [8:0] nv;
  logic [11:0] sv;
  logic [8:0] pfx[3];
  int mismatches, check_count;
  spg_packetizer #(.MS_CYC(10)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ser_rx_i(ser_rx),
    .bus_rx_busy_i(busy), .net_rx_i(net_rx), .net_rx_client_i(net_client), .net_conn_i(conn),
    .net_tx_o(net_tx), .ser_tx_o(ser_tx), .ser_tx_client_o(ser_client), .poll_to_o(poll_to),
    .poll_to_client_o(poll_client));
  spg_far_model far (.clk_i(clk_i), .ser_rx_o(ser_rx), .bus_busy_o(busy), .net_rx_o(net_rx),
    .net_client_o(net_client), .net_conn_o(conn), .net_tx_i(net_tx), .ser_tx_i(ser_tx),
    .ser_tx_client_i(ser_client));
  // --------------------------------------------------
  // shared tasks
  // --------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // bounded waits: running out counts as a mismatch and ends the run
  task automatic get_net(output logic [8:0] v);
    for (int i = 0; i < 300 && far.net_q.size() == 0; i++) @(posedge clk_i);
    if (far.net_q.size() == 0) begin
      mismatches++;
      report_and_stop();
    end else begin
      v = far.net_q.pop_front();
    end
  endtask
  task automatic get_ser(output logic [11:0] v);
    for (int i = 0; i < 300 && far.ser_q.size() == 0; i++) @(posedge clk_i);
    if (far.ser_q.size() == 0) begin
      mismatches++;
      report_and_stop();
    end else begin
      v = far.ser_q.pop_front();
    end
  endtask
  task automatic no_out(input int n);
    repeat (n) @(posedge clk_i);
    check(far.net_q.size() + far.ser_q.size(), 32'h0);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    mismatches = 0;
    check_count = 0;
    pfx = '{9'h0a5, 9'h03c, 9'h15e};
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(spg_pkg::A_IDLE, rv);
    check(rv, 32'h0000000a);
    rd_reg(spg_pkg::A_CTRL, rv);
    check(rv, 32'h0);
    rd_reg(spg_pkg::A_BAUD, rv);
    check(rv, 32'h00002580);
    rd_reg(8'hfc, rv);
    check(rv, 32'h0);
    // length delimiter, clamp at the top of the range
    wr_reg(spg_pkg::A_LEN, 32'h0000ffff);
    rd_reg(spg_pkg::A_LEN, rv);
    check(rv, {21'h0, spg_pkg::LEN_MAX});
    wr_reg(spg_pkg::A_LEN, 32'h3);
    for (int i = 0; i < 3; i++) far.ser_byte(8'h10 + 8'(i));
    for (int i = 0; i < 3; i++) begin
      get_net(nv);
      check(nv, {i == 2, 8'h10 + 8'(i)});
    end
    rd_reg(spg_pkg::A_STAT, rv);
    check(rv[10:0], 11'h0);
    // both delimiters off: bytes stay buffered until the gap is switched on
    wr_reg(spg_pkg::A_LEN, 32'h0);
    far.ser_byte(8'h21);
    far.ser_byte(8'h22);
    no_out(100);
    wr_reg(spg_pkg::A_GAP, 32'h2);
    wr_reg(spg_pkg::A_CTRL, 32'h3);
    get_net(nv);
    check(nv, 9'h021);
    get_net(nv);
    check(nv, 9'h122);
    rd_reg(spg_pkg::A_STAT, rv);
    check(rv[10:0], 11'h0);
    // registration prefix, clamp on its length
    wr_reg(spg_pkg::A_REGLEN, 32'hff);
    rd_reg(spg_pkg::A_REGLEN, rv);
    check(rv, {26'h0, spg_pkg::REG_MAX});
    wr_reg(spg_pkg::A_REGLEN, 32'h2);
    wr_reg(8'h40, 32'ha5);
    wr_reg(8'h41, 32'h3c);
    wr_reg(spg_pkg::A_LEN, 32'h1);
    wr_reg(spg_pkg::A_CTRL, 32'h84);
    far.ser_byte(8'h5e);
    for (int i = 0; i < 3; i++) begin
      get_net(nv);
      check(nv, pfx[i]);
    end
    wr_reg(spg_pkg::A_CTRL, 32'h4);
    far.ser_byte(8'h61);
    get_net(nv);
    check(nv, 9'h161);
    // once per connection in tcp client mode
    wr_reg(spg_pkg::A_CTRL, 32'h48);
    far.set_conn(1'b1);
    for (int i = 0; i < 2; i++) begin
      get_net(nv);
      check(nv[7:0], pfx[i][7:0]);
    end
    no_out(60);
    // rs485 gate and idle time
    wr_reg(spg_pkg::A_CTRL, 32'h0);
    wr_reg(spg_pkg::A_IDLE, 32'h2);
    far.set_busy(1'b1);
    far.net_byte(8'h71, 4'hf);
    no_out(20);
    far.set_busy(1'b0);
    far.net_byte(8'h72, 4'hf);
    no_out(5);
    repeat (40) @(posedge clk_i);
    far.net_byte(8'h73, 4'hf);
    get_ser(sv);
    check(sv, 12'hf73);
    // polling: no answer within the timeout
    wr_reg(spg_pkg::A_RTO, 32'h1);
    wr_reg(spg_pkg::A_CTRL, 32'h100);
    far.net_byte(8'h81, 4'h5);
    get_ser(sv);
    check(sv, 12'h581);
    for (int i = 0; i < 100 && poll_to !== 1'b1; i++) @(posedge clk_i) #1;
    check(poll_to, 1'b1);
    check(poll_client, 4'h5);
    // serial heartbeat after a quiet interval
    wr_reg(spg_pkg::A_CTRL, 32'h10);
    wr_reg(spg_pkg::A_HBDAT, 32'h77);
    wr_reg(spg_pkg::A_HB, 32'h2);
    get_ser(sv);
    check(sv[7:0], 8'h77);
    // network heartbeat only in client modes
    wr_reg(spg_pkg::A_CTRL, 32'h20);
    rd_reg(spg_pkg::A_STAT, rv);
    repeat (60) @(posedge clk_i);
    rd_reg(spg_pkg::A_STAT, rv);
    check(rv[31], 1'b0);
    wr_reg(spg_pkg::A_CTRL, 32'h60);
    repeat (60) @(posedge clk_i);
    rd_reg(spg_pkg::A_STAT, rv);
    check(rv[31], 1'b1);
    // derived gap at 1200 baud: 10000/1200 + 2 = 10 ms, above the 8.3 ms character time
    wr_reg(spg_pkg::A_BAUD, 32'h000004b0);
    rd_reg(spg_pkg::A_BAUD, rv);
    check(rv, 32'h000004b0);
    rd_reg(spg_pkg::A_STAT, rv);
    check(rv[25:18], 8'h0a);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
